// File: bst_tap_map.svh
`ifndef BST_TAP_MAP_SVH
`define BST_TAP_MAP_SVH

// Instruction opcodes; only the all-zero external-test code is fixed
`define BST_OP_EXTEST 3'h0
`define BST_OP_IDCODE_DEF 3'h1
`define BST_OP_SAMPLE_Z_DEF 3'h2
`define BST_OP_SAMPLE_DEF 3'h4
`define BST_OP_BYPASS_DEF 3'h7

// Arbitrary identification value, bit 0 set as the scan convention asks
`define BST_ID_VALUE_DEF 32'h0a5c_3e01

// Default boundary register length
`define BST_BSR_LEN_DEF 8

// Register widths, capture patterns and the TMS-high edge count to reset
`define BST_IR_W 3
`define BST_ID_W 32
`define BST_IR_CAPTURE 2'h1
`define BST_BYP_CAPTURE 1'h0
`define BST_TMS_RESET_EDGES 3'h5

`endif

// File: bst_pkg.sv
package bst_pkg;

  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_SEL_DR,
    ST_CAPTURE_DR,
    ST_SHIFT_DR,
    ST_EXIT1_DR,
    ST_PAUSE_DR,
    ST_EXIT2_DR,
    ST_UPDATE_DR,
    ST_SEL_IR,
    ST_CAPTURE_IR,
    ST_SHIFT_IR,
    ST_EXIT1_IR,
    ST_PAUSE_IR,
    ST_EXIT2_IR,
    ST_UPDATE_IR
  } bst_state_e;

  typedef enum logic [1:0] {
    SEL_BYPASS,
    SEL_IDCODE,
    SEL_BOUNDARY
  } bst_sel_e;

  // Serial output pin: data and driver enable travel together
  typedef struct packed {
    logic data;
    logic oe;
  } bst_tdo_s;

endpackage : bst_pkg

// File: bst_sync.sv
`timescale 1ns/100ps

module bst_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] q_d;

  // First stage feeds the second stage only
  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{RST_VAL}};
      q <= {WIDTH{RST_VAL}};
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end

endmodule : bst_sync

// File: bst_tap.sv
`timescale 1ns/100ps
`include "bst_tap_map.svh"

module bst_tap #(
  parameter int unsigned BSR_LEN = `BST_BSR_LEN_DEF,
  parameter bit BSR_REVERSE = 1'b0,
  parameter logic [`BST_IR_W-1:0] OP_IDCODE = `BST_OP_IDCODE_DEF,
  parameter logic [`BST_IR_W-1:0] OP_SAMPLE_Z = `BST_OP_SAMPLE_Z_DEF,
  parameter logic [`BST_IR_W-1:0] OP_SAMPLE = `BST_OP_SAMPLE_DEF,
  parameter logic [`BST_IR_W-1:0] OP_BYPASS = `BST_OP_BYPASS_DEF,
  parameter logic [`BST_ID_W-1:0] ID_VALUE = `BST_ID_VALUE_DEF
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic [BSR_LEN-1:0] ring_pins,
  output bst_pkg::bst_tdo_s tdo,
  output logic mem_out_hiz
);
  import bst_pkg::*;

  logic core_rst_n;
  logic tap_rst_n;
  logic [BSR_LEN-1:0] ring_s;
  logic [BSR_LEN-1:0] ring_ord;

  bst_state_e st_q;
  bst_state_e st_d;
  logic [`BST_IR_W-1:0] ir_q;
  logic [`BST_IR_W-1:0] ir_d;
  logic [`BST_IR_W-1:0] ir_sr_q;
  logic [`BST_IR_W-1:0] ir_sr_d;
  logic byp_q;
  logic byp_d;
  logic [`BST_ID_W-1:0] id_sr_q;
  logic [`BST_ID_W-1:0] id_sr_d;
  logic [BSR_LEN-1:0] bsr_q;
  logic [BSR_LEN-1:0] bsr_d;
  logic hiz_q;
  logic hiz_d;
  bst_tdo_s tdo_q;
  bst_tdo_s tdo_d;
  bst_sel_e sel;

  // Core reset released through two flops; unused by the test path, so a
  // test-logic reset reaches memory-side state only by clearing the float request
  bst_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_core_rst (
    .clk(core_clk),
    .rst_n(reset_n),
    .d(1'b1),
    .q(core_rst_n)
  );

  // Power-up reset asserts at once even with the test clock still
  bst_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_tap_rst (
    .clk(tck),
    .rst_n(reset_n),
    .d(1'b1),
    .q(tap_rst_n)
  );

  // Ring pins change on the memory clock; sample them before capture
  bst_sync #(.WIDTH(BSR_LEN), .RST_VAL(1'b0)) u_ring_sync (
    .clk(tck),
    .rst_n(tap_rst_n),
    .d(ring_pins),
    .q(ring_s)
  );

  // Float request is a level, so a two-flop crossing is enough
  bst_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_hiz_sync (
    .clk(core_clk),
    .rst_n(core_rst_n),
    .d(hiz_q),
    .q(mem_out_hiz)
  );

  // Bit-to-pin order of the boundary register
  for (genvar i = 0; i < BSR_LEN; i++) begin : g_ring_ord
    assign ring_ord[i] = BSR_REVERSE ? ring_s[BSR_LEN-1-i] : ring_s[i];
  end

  // Controller next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_RESET: st_d = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: st_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: st_d = tms ? ST_SEL_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: st_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: st_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: st_d = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: st_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: st_d = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR: st_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: st_d = tms ? ST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_IR: st_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: st_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: st_d = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: st_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: st_d = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR: st_d = tms ? ST_SEL_DR : ST_IDLE;
      default: st_d = ST_RESET;
    endcase
  end

  // Data register selection; reserved opcodes fall back to bypass
  always_comb begin
    if (ir_q == `BST_OP_EXTEST || ir_q == OP_SAMPLE ||
        ir_q == OP_SAMPLE_Z) begin
      sel = SEL_BOUNDARY;
    end else if (ir_q == OP_IDCODE) begin
      sel = SEL_IDCODE;
    end else if (ir_q == OP_BYPASS) begin
      sel = SEL_BYPASS;
    end else begin
      sel = SEL_BYPASS;
    end
  end

  // Instruction path
  always_comb begin
    ir_d = ir_q;
    ir_sr_d = ir_sr_q;
    case (st_q)
      ST_RESET: ir_d = OP_IDCODE;
      ST_CAPTURE_IR: ir_sr_d = {ir_sr_q[`BST_IR_W-1], `BST_IR_CAPTURE};
      ST_SHIFT_IR: ir_sr_d = {tdi, ir_sr_q[`BST_IR_W-1:1]};
      ST_UPDATE_IR: ir_d = ir_sr_q;
      default: ir_d = ir_q;
    endcase
  end

  // Data registers; only the selected one moves
  always_comb begin
    byp_d = byp_q;
    id_sr_d = id_sr_q;
    bsr_d = bsr_q;
    if (st_q == ST_CAPTURE_DR) begin
      case (sel)
        SEL_BYPASS: byp_d = `BST_BYP_CAPTURE;
        SEL_IDCODE: id_sr_d = ID_VALUE;
        SEL_BOUNDARY: bsr_d = ring_ord;
        default: byp_d = `BST_BYP_CAPTURE;
      endcase
    end else if (st_q == ST_SHIFT_DR) begin
      case (sel)
        SEL_BYPASS: byp_d = tdi;
        SEL_IDCODE: id_sr_d = {tdi, id_sr_q[`BST_ID_W-1:1]};
        SEL_BOUNDARY: bsr_d = {tdi, bsr_q[BSR_LEN-1:1]};
        default: byp_d = tdi;
      endcase
    end
    // No preload: Update-DR leaves the captured ring values alone
  end

  // Outputs float under external-test and sample-outputs-off
  always_comb begin
    hiz_d = (ir_q == `BST_OP_EXTEST) || (ir_q == OP_SAMPLE_Z);
  end

  // Serial output chosen from the register in the current shift state
  always_comb begin
    tdo_d.data = tdo_q.data;
    tdo_d.oe = 1'b0;
    if (st_q == ST_SHIFT_IR) begin
      tdo_d.data = ir_sr_q[0];
      tdo_d.oe = 1'b1;
    end else if (st_q == ST_SHIFT_DR) begin
      tdo_d.oe = 1'b1;
      case (sel)
        SEL_IDCODE: tdo_d.data = id_sr_q[0];
        SEL_BOUNDARY: tdo_d.data = bsr_q[0];
        default: tdo_d.data = byp_q;
      endcase
    end
  end

  // Sampling edge
  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      st_q <= ST_RESET;
      ir_q <= OP_IDCODE;
      ir_sr_q <= '0;
      byp_q <= 1'b0;
      id_sr_q <= '0;
      bsr_q <= '0;
      hiz_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ir_q <= ir_d;
      ir_sr_q <= ir_sr_d;
      byp_q <= byp_d;
      id_sr_q <= id_sr_d;
      bsr_q <= bsr_d;
      hiz_q <= hiz_d;
    end
  end

  // Output edge: falling clock keeps TDO stable around the tester's sample
  always_ff @(negedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_q <= '0;
    end else begin
      tdo_q <= tdo_d;
    end
  end

  assign tdo = tdo_q;

  chk_tms_reset_walk: assert property (
    @(posedge tck) disable iff (!tap_rst_n)
    tms [*5] |=> st_q == ST_RESET)
    else $error("five TMS-high edges did not reach reset");

  chk_ir_reset_load: assert property (
    @(posedge tck) disable iff (!tap_rst_n)
    st_q == ST_RESET |=> ir_q == OP_IDCODE)
    else $error("reset state did not load identification");

  chk_ir_capture_pat: assert property (
    @(posedge tck) disable iff (!tap_rst_n)
    st_q == ST_CAPTURE_IR |=> ir_sr_q[1:0] == `BST_IR_CAPTURE)
    else $error("Capture-IR pattern wrong");

  chk_ir_update_only: assert property (
    @(posedge tck) disable iff (!tap_rst_n)
    (st_q != ST_UPDATE_IR && st_q != ST_RESET) |=> $stable(ir_q))
    else $error("instruction changed outside Update-IR");

  chk_bypass_clear: assert property (
    @(posedge tck) disable iff (!tap_rst_n)
    st_q == ST_CAPTURE_DR && sel == SEL_BYPASS ##1 st_q == ST_SHIFT_DR
    |-> byp_q == 1'b0 && tdo_d.data == 1'b0)
    else $error("bypass not cleared on capture");

  chk_idcode_shift: assert property (
    @(posedge tck) disable iff (!tap_rst_n)
    st_q == ST_CAPTURE_DR && sel == SEL_IDCODE ##1 st_q == ST_SHIFT_DR
    |-> tdo_d.data == ID_VALUE[0] ##1 id_sr_q[`BST_ID_W-1] == $past(tdi))
    else $error("identification code not shifted out");

  chk_bsr_capture: assert property (
    @(posedge tck) disable iff (!tap_rst_n)
    st_q == ST_CAPTURE_DR && sel == SEL_BOUNDARY |=> bsr_q == $past(ring_ord))
    else $error("boundary register missed the ring");

  chk_tdo_oe_state: assert property (
    @(posedge tck) disable iff (!tap_rst_n)
    tdo_q.oe == (st_q == ST_SHIFT_DR || st_q == ST_SHIFT_IR))
    else $error("TDO driven outside a shift state");

  chk_tdo_falling: assert property (
    @(posedge tck) disable iff (!tap_rst_n)
    tdo_q == tdo_d)
    else $error("TDO moved on a rising edge");

  chk_hiz_instr: assert property (
    @(posedge tck) disable iff (!tap_rst_n)
    st_q == ST_UPDATE_IR && ir_sr_q == `BST_OP_EXTEST |=> ##1 hiz_q)
    else $error("external-test did not float outputs");

  chk_hiz_sample_z: assert property (
    @(posedge tck) disable iff (!tap_rst_n)
    st_q == ST_UPDATE_IR && ir_sr_q == OP_SAMPLE_Z |=> ##1 hiz_q)
    else $error("sample-outputs-off did not float outputs");

  cov_float_req: cover property (
    @(posedge tck) disable iff (!tap_rst_n)
    $rose(hiz_q));

  cov_idcode_read: cover property (
    @(posedge tck) disable iff (!tap_rst_n)
    st_q == ST_SHIFT_DR && sel == SEL_IDCODE);

  cov_ir_update: cover property (
    @(posedge tck) disable iff (!tap_rst_n)
    st_q == ST_UPDATE_IR ##1 sel == SEL_BOUNDARY);

  cov_bypass_shift: cover property (
    @(posedge tck) disable iff (!tap_rst_n)
    st_q == ST_SHIFT_DR && sel == SEL_BYPASS);

endmodule : bst_tap

// File: bst_jtag_ctl.sv
`timescale 1ns/100ps

module bst_jtag_ctl (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire bst_pkg::bst_tdo_s tdo
);
  import bst_pkg::*;

  int n_oe_bad;
  logic last_q;
  logic seen;

  // Test clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    n_oe_bad = 0;
    last_q = 1'b0;
    seen = 1'b0;
  end

  task automatic step(input logic m, input logic d, input logic oe_exp);
    #1;
    tms = m;
    tdi = d;
    #61.5;
    tck = 1'b1;
    if (tdo.oe !== oe_exp) n_oe_bad++;
    // No pull on the output, so a floating line shows the inverted bit
    seen = tdo.oe ? tdo.data : ~last_q;
    last_q = seen;
    #62.5;
    tck = 1'b0;
  endtask : step

  // Internal pull-ups take the lines high once released
  task automatic idle();
    tms = 1'b1;
    tdi = 1'b1;
  endtask : idle

  task automatic reset5();
    repeat (5) step(1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    idle();
  endtask : reset5

  task automatic scan_ir(input logic [2:0] op, input logic upd,
                         output logic [2:0] cap);
    step(1'b1, 1'b1, 1'b0);
    step(1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      step(i == 2, op[i], 1'b1);
      cap[i] = seen;
    end
    if (upd) begin
      step(1'b1, 1'b1, 1'b0);
      step(1'b0, 1'b1, 1'b0);
    end else begin
      step(1'b0, 1'b1, 1'b0);
    end
    idle();
  endtask : scan_ir

  task automatic scan_dr(input int n, input logic [31:0] din,
                         output logic [31:0] dout);
    dout = 32'h0;
    step(1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], 1'b1);
      dout[i] = seen;
    end
    step(1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    idle();
  endtask : scan_dr
endmodule : bst_jtag_ctl

// File: bst_tap_tb.sv
`timescale 1ns/100ps
`include "bst_tap_map.svh"

module bst_tap_tb;
  import bst_pkg::*;

  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic tck;
  logic tms;
  logic tdi;
  logic [7:0] ring_pins = 8'h00;
  bst_tdo_s tdo;
  logic mem_out_hiz;
  int n_errors = 0;
  int checked = 0;

  always #4 core_clk = ~core_clk;

  bst_tap #(.BSR_LEN(8)) i_dut (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .ring_pins(ring_pins),
    .tdo(tdo),
    .mem_out_hiz(mem_out_hiz)
  );

  bst_jtag_ctl i_ctl (
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // Float request follows the instruction one test clock late, then
  // crosses two core flops; TMS low keeps Idle or Pause-IR in place
  task automatic settle();
    i_ctl.step(1'b0, 1'b1, 1'b0);
    repeat (6) @(negedge core_clk);
  endtask : settle

  task automatic t_power_up();
    logic [31:0] d;
    check(tdo.oe, 1'b0);
    check(mem_out_hiz, 1'b0);
    i_ctl.reset5();
    i_ctl.scan_dr(32, 32'h0, d);
    check(d, `BST_ID_VALUE_DEF);
  endtask : t_power_up

  task automatic t_opcodes();
    logic [2:0] cap;
    logic [31:0] d;
    logic [31:0] exp;
    logic [8:0] din;
    logic hiz;
    din = 9'h1a5;
    for (int op = 0; op < 8; op++) begin
      @(negedge core_clk);
      ring_pins = 8'h96 ^ 8'(op * 37);
      i_ctl.scan_ir(3'(op), 1'b1, cap);
      check(cap[1:0], 2'h1);
      settle();
      hiz = (3'(op) == `BST_OP_EXTEST) || (3'(op) == `BST_OP_SAMPLE_Z_DEF);
      check(mem_out_hiz, hiz);
      i_ctl.scan_dr(9, {23'h0, din}, d);
      if (3'(op) == `BST_OP_IDCODE_DEF) begin
        exp = `BST_ID_VALUE_DEF & 32'h1ff;
      end else if (hiz || 3'(op) == `BST_OP_SAMPLE_DEF) begin
        exp = {23'h0, din[0], ring_pins};
      end else begin
        // Unlisted codes fall back to the one-bit path
        exp = {23'h0, din[7:0], 1'b0};
      end
      check(d, exp);
    end
  endtask : t_opcodes

  task automatic t_no_update();
    logic [2:0] cap;
    logic [31:0] d;
    i_ctl.scan_ir(`BST_OP_SAMPLE_Z_DEF, 1'b1, cap);
    settle();
    check(mem_out_hiz, 1'b1);
    // Parked in Pause-IR: the shifted code must not act yet
    i_ctl.scan_ir(`BST_OP_SAMPLE_DEF, 1'b0, cap);
    settle();
    check(mem_out_hiz, 1'b1);
    i_ctl.reset5();
    settle();
    check(mem_out_hiz, 1'b0);
    i_ctl.scan_dr(32, 32'hffff_ffff, d);
    check(d, `BST_ID_VALUE_DEF);
  endtask : t_no_update

  initial begin
    repeat (10) @(negedge core_clk);
    t_power_up();
    t_opcodes();
    t_no_update();
    check(i_ctl.n_oe_bad, 32'h0);
    test_done();
  end

  // Release reset at a falling edge, away from the sampling edge
  initial begin
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
  end

  initial begin
    #500000;
    n_errors++;
    test_done();
  end
endmodule : bst_tap_tb
